// file: design/ptp_adjust_map.svh
`ifndef PTP_ADJUST_MAP_SVH
`define PTP_ADJUST_MAP_SVH

`define ADDR_W                 9
`define OFS_TEMP_RATE_COUNT    9'h124
`define OFS_STEP_ADJUST        9'h128
`define OFS_COMPARE_SEC_A      9'h12C
`define OFS_COMPARE_NS_A       9'h130
`define OFS_REARM_SEC_A        9'h134
`define OFS_REARM_NS_A         9'h138
`define OFS_COMPARE_SEC_B      9'h13C
`define OFS_COMPARE_NS_B       9'h140
`define OFS_REARM_SEC_B        9'h144
`define OFS_REARM_NS_B         9'h148
`define OFS_COMMAND            9'h1F0
`define OFS_CHANNEL_CONFIG     9'h1F4
`define OFS_TEMP_REMAINING     9'h1F8
`define OFS_CLOCK_SEC          9'h1E0
`define OFS_CLOCK_NS           9'h1E4

`define CMD_TARGET_READ_A      0
`define CMD_TARGET_READ_B      1
`define CMD_STEP_SECONDS       2
`define CMD_STEP_NANOSECONDS   3
`define CMD_TEMP_RATE_START    4

`define CFG_ENABLE_A           0
`define CFG_RELOAD_ADD_A       1
`define CFG_ENABLE_B           2
`define CFG_RELOAD_ADD_B       3
`define CFG_W                  4

`define STEP_DIR_BIT           31
`define RATE_DIR_BIT           31
`define NS_W                   30
`define STEP_SEC_W             4
`define RESET_WORD             32'h00000000
`define RESERVED_NS_BITS       2'h0

`define NS_PER_SEC             30'h3B9ACA00
`define REF_PERIOD_NS          30'h0000000A
`define PERIOD_SLOW_NS         30'h00000009
`define PERIOD_FAST_NS         30'h0000000B

`endif

// file: design/ptp_adjust_pkg.sv
`include "ptp_adjust_map.svh"

package ptp_adjust_pkg;

	typedef struct packed
	{
		logic [31:0]         seconds;
		logic [`NS_W-1:0]    nanoseconds;
	} ptp_time_type;

	typedef struct packed
	{
		logic [`ADDR_W-1:0]  addr;
		logic [31:0]         wdata;
		logic                wr;
		logic                rd;
	} reg_req_type;

	typedef struct packed
	{
		logic                wr_sec;
		logic                wr_ns;
		logic                wr_rearm_sec;
		logic                wr_rearm_ns;
		logic [31:0]         wdata;
		logic                target_read;
		logic                enable;
		logic                reload_add;
	} channel_ctl_type;

	typedef struct packed
	{
		logic [31:0]         compare_sec;
		logic [`NS_W-1:0]    compare_ns;
		logic [31:0]         rearm_sec;
		logic [`NS_W-1:0]    rearm_ns;
	} channel_view_type;

	// Adds seconds and nanoseconds, folding one nanosecond overflow into the seconds.
	function automatic ptp_time_type time_add(ptp_time_type t, logic [31:0] sec, logic [`NS_W-1:0] ns);
		logic [`NS_W:0] sum;
		ptp_time_type   r;
		sum = {1'b0, t.nanoseconds} + {1'b0, ns};
		r.seconds = t.seconds + sec;
		r.nanoseconds = sum[`NS_W-1:0];
		if (sum >= {1'b0, `NS_PER_SEC})
		begin
			r.nanoseconds = sum[`NS_W-1:0] - `NS_PER_SEC;
			r.seconds = t.seconds + sec + 32'h00000001;
		end
		return r;
	endfunction

	function automatic logic time_reached(ptp_time_type now, ptp_time_type tgt);
		return (now.seconds > tgt.seconds) ||
			((now.seconds == tgt.seconds) && (now.nanoseconds >= tgt.nanoseconds));
	endfunction

endpackage

// file: design/ptp_clock_adjust.sv
// Operation
// - Hold a 32-bit count of reference cycles for the temporary rate.
// - Step direction bit 31: zero subtracts the step, one adds it.
// - Nanosecond steps only ever add; subtraction is not offered.
// - A seconds step uses only the low four bits of the amount.
// - Each channel compares its target with the clock and raises a match event.
// - Target nanoseconds in bits 29 to 0; bits 31 to 30 read as zero.
// - Target halves take effect together only after both are written.
// - Target reads return the last written half, or the snapshot taken by the target-read command.
// - The target-read command overwrites uncommitted written target halves.
// - On a match the target is loaded with, or advanced by, the reload value.
// - Reload halves take effect together only after both are written.
// - The clock advances a nominal 10 ns each reference cycle.
// - While temporary, its adjustment feeds the sub-nanosecond accumulator.
// - Reload nanoseconds in bits 29 to 0; bits 31 to 30 read as zero.
//
// The address-and-strobe port was chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
`include "ptp_adjust_map.svh"

module ptp_clock_adjust
(
	input  wire logic                          ref_clk_i,          // Reference clock.
	input  wire logic                          rstn_i,             // Asynchronous reset, active low.
	input  wire ptp_adjust_pkg::reg_req_type   reg_req_i,          // Register address, data and strobes.
	output logic [31:0]                        reg_rdata_o,        // Read data, one cycle after the strobe.
	input  wire logic [31:0]                   base_rate_adj_i,    // Base rate adjustment word.
	input  wire logic [31:0]                   temp_rate_adj_i,    // Temporary rate adjustment word.
	output ptp_adjust_pkg::ptp_time_type       clock_time_o,       // Running clock value.
	output logic                               event_a_o,          // Channel A compare event pulse.
	output logic                               event_b_o           // Channel B compare event pulse.
);
	import ptp_adjust_pkg::*;

	typedef struct packed
	{
		ptp_time_type        now;
		logic [31:0]         temp_count;
		logic [31:0]         step;
		logic [`CFG_W-1:0]   config_bits;
		logic [31:0]         rdata;
	} main_state_type;

	main_state_type    state_reg;
	main_state_type    state_next;
	channel_ctl_type   ctl_a;
	channel_ctl_type   ctl_b;
	channel_view_type  view_a;
	channel_view_type  view_b;
	logic [`NS_W-1:0]  increment;
	logic [31:0]       remaining;
	logic              cmd_write;
	logic              target_read_a;
	logic              target_read_b;
	logic              step_seconds;
	logic              step_nanoseconds;
	logic              temp_start;
	logic              match_a;
	logic              match_b;

	function automatic logic write_to(reg_req_type req, logic [`ADDR_W-1:0] ofs);
		return req.wr && (req.addr == ofs);
	endfunction

	function automatic logic [31:0] ns_word(logic [`NS_W-1:0] ns);
		return {`RESERVED_NS_BITS, ns};
	endfunction

	// Command bits act for one cycle only; the command word reads back as zero.
	assign cmd_write = write_to(reg_req_i, `OFS_COMMAND);
	assign target_read_a = cmd_write && reg_req_i.wdata[`CMD_TARGET_READ_A];
	assign target_read_b = cmd_write && reg_req_i.wdata[`CMD_TARGET_READ_B];
	assign step_seconds = cmd_write && reg_req_i.wdata[`CMD_STEP_SECONDS];
	assign step_nanoseconds = cmd_write && reg_req_i.wdata[`CMD_STEP_NANOSECONDS];
	assign temp_start = cmd_write && reg_req_i.wdata[`CMD_TEMP_RATE_START];

	always_comb
	begin
		ctl_a = '0;
		ctl_a.wdata = reg_req_i.wdata;
		ctl_a.wr_sec = write_to(reg_req_i, `OFS_COMPARE_SEC_A);
		ctl_a.wr_ns = write_to(reg_req_i, `OFS_COMPARE_NS_A);
		ctl_a.wr_rearm_sec = write_to(reg_req_i, `OFS_REARM_SEC_A);
		ctl_a.wr_rearm_ns = write_to(reg_req_i, `OFS_REARM_NS_A);
		ctl_a.target_read = target_read_a;
		ctl_a.enable = state_reg.config_bits[`CFG_ENABLE_A];
		ctl_a.reload_add = state_reg.config_bits[`CFG_RELOAD_ADD_A];
	end

	always_comb
	begin
		ctl_b = '0;
		ctl_b.wdata = reg_req_i.wdata;
		ctl_b.wr_sec = write_to(reg_req_i, `OFS_COMPARE_SEC_B);
		ctl_b.wr_ns = write_to(reg_req_i, `OFS_COMPARE_NS_B);
		ctl_b.wr_rearm_sec = write_to(reg_req_i, `OFS_REARM_SEC_B);
		ctl_b.wr_rearm_ns = write_to(reg_req_i, `OFS_REARM_NS_B);
		ctl_b.target_read = target_read_b;
		ctl_b.enable = state_reg.config_bits[`CFG_ENABLE_B];
		ctl_b.reload_add = state_reg.config_bits[`CFG_RELOAD_ADD_B];
	end

	// Two identical channels, each with its own registers and event.
	ptp_compare_channel channel_a
	(
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.ctl_i     (ctl_a),
		.now_i     (state_reg.now),
		.view_o    (view_a),
		.match_o   (match_a)
	);

	ptp_compare_channel channel_b
	(
		.ref_clk_i (ref_clk_i),
		.rstn_i    (rstn_i),
		.ctl_i     (ctl_b),
		.now_i     (state_reg.now),
		.view_o    (view_b),
		.match_o   (match_b)
	);

	ptp_rate_select rate
	(
		.ref_clk_i   (ref_clk_i),
		.rstn_i      (rstn_i),
		.start_i     (temp_start),
		.duration_i  (state_reg.temp_count),
		.base_adj_i  (base_rate_adj_i),
		.temp_adj_i  (temp_rate_adj_i),
		.increment_o (increment),
		.remaining_o (remaining)
	);

	always_comb
	begin
		logic [31:0]      sec_step;
		logic [`NS_W-1:0] ns_add;
		sec_step = {28'h0000000, state_reg.step[`STEP_SEC_W-1:0]};
		ns_add = increment;
		state_next = state_reg;
		state_next.rdata = 32'h00000000;

		if (write_to(reg_req_i, `OFS_TEMP_RATE_COUNT))
			state_next.temp_count = reg_req_i.wdata;
		if (write_to(reg_req_i, `OFS_STEP_ADJUST))
			state_next.step = {reg_req_i.wdata[`STEP_DIR_BIT], 1'b0, reg_req_i.wdata[`NS_W-1:0]};
		if (write_to(reg_req_i, `OFS_CHANNEL_CONFIG))
			state_next.config_bits = reg_req_i.wdata[`CFG_W-1:0];

		// A nanosecond step always adds and replaces this cycle's increment.
		if (step_nanoseconds)
			ns_add = state_reg.step[`NS_W-1:0];
		state_next.now = time_add(state_reg.now, 32'h00000000, ns_add);
		if (step_seconds)
		begin
			if (state_reg.step[`STEP_DIR_BIT])
				state_next.now.seconds = state_next.now.seconds + sec_step;
			else
				state_next.now.seconds = state_next.now.seconds - sec_step;
		end

		if (reg_req_i.rd)
		begin
			case (reg_req_i.addr)
				`OFS_TEMP_RATE_COUNT:
					state_next.rdata = state_reg.temp_count;
				`OFS_STEP_ADJUST:
					state_next.rdata = state_reg.step;
				`OFS_COMPARE_SEC_A:
					state_next.rdata = view_a.compare_sec;
				`OFS_COMPARE_NS_A:
					state_next.rdata = ns_word(view_a.compare_ns);
				`OFS_REARM_SEC_A:
					state_next.rdata = view_a.rearm_sec;
				`OFS_REARM_NS_A:
					state_next.rdata = ns_word(view_a.rearm_ns);
				`OFS_COMPARE_SEC_B:
					state_next.rdata = view_b.compare_sec;
				`OFS_COMPARE_NS_B:
					state_next.rdata = ns_word(view_b.compare_ns);
				`OFS_REARM_SEC_B:
					state_next.rdata = view_b.rearm_sec;
				`OFS_REARM_NS_B:
					state_next.rdata = ns_word(view_b.rearm_ns);
				`OFS_CHANNEL_CONFIG:
					state_next.rdata = {28'h0000000, state_reg.config_bits};
				`OFS_TEMP_REMAINING:
					state_next.rdata = remaining;
				`OFS_CLOCK_SEC:
					state_next.rdata = state_reg.now.seconds;
				`OFS_CLOCK_NS:
					state_next.rdata = ns_word(state_reg.now.nanoseconds);
				default:
					state_next.rdata = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign reg_rdata_o = state_reg.rdata;
	assign clock_time_o = state_reg.now;
	assign event_a_o = match_a;
	assign event_b_o = match_b;

endmodule
`default_nettype wire

// file: design/ptp_compare_channel.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptp_adjust_map.svh"

module ptp_compare_channel
(
	input  wire logic                             ref_clk_i,  // Reference clock.
	input  wire logic                             rstn_i,     // Asynchronous reset, active low.
	input  wire ptp_adjust_pkg::channel_ctl_type  ctl_i,      // Writes, commands and mode.
	input  wire ptp_adjust_pkg::ptp_time_type     now_i,      // Running clock value.
	output ptp_adjust_pkg::channel_view_type      view_o,     // Readback of the channel.
	output logic                                  match_o     // One-cycle compare event.
);
	import ptp_adjust_pkg::*;

	typedef struct packed
	{
		channel_view_type shown;
		logic             sec_written;
		logic             ns_written;
		logic             rsec_written;
		logic             rns_written;
		ptp_time_type     target;
		ptp_time_type     rearm;
		logic             match;
	} channel_state_type;

	channel_state_type state_reg;
	channel_state_type state_next;

	always_comb
	begin
		state_next = state_reg;
		state_next.match = 1'b0;
		if (ctl_i.wr_sec)
		begin
			state_next.shown.compare_sec = ctl_i.wdata;
			state_next.sec_written = 1'b1;
		end
		if (ctl_i.wr_ns)
		begin
			state_next.shown.compare_ns = ctl_i.wdata[`NS_W-1:0];
			state_next.ns_written = 1'b1;
		end
		if (ctl_i.wr_rearm_sec)
		begin
			state_next.shown.rearm_sec = ctl_i.wdata;
			state_next.rsec_written = 1'b1;
		end
		if (ctl_i.wr_rearm_ns)
		begin
			state_next.shown.rearm_ns = ctl_i.wdata[`NS_W-1:0];
			state_next.rns_written = 1'b1;
		end
		if (ctl_i.enable && time_reached(now_i, state_reg.target))
		begin
			state_next.match = 1'b1;
			state_next.target = ctl_i.reload_add ?
				time_add(state_reg.target, state_reg.rearm.seconds, state_reg.rearm.nanoseconds) :
				state_reg.rearm;
		end
		if (state_next.sec_written && state_next.ns_written)
		begin
			state_next.target = '{seconds: state_next.shown.compare_sec,
				nanoseconds: state_next.shown.compare_ns};
			state_next.sec_written = 1'b0;
			state_next.ns_written = 1'b0;
		end
		if (state_next.rsec_written && state_next.rns_written)
		begin
			state_next.rearm = '{seconds: state_next.shown.rearm_sec,
				nanoseconds: state_next.shown.rearm_ns};
			state_next.rsec_written = 1'b0;
			state_next.rns_written = 1'b0;
		end
		if (ctl_i.target_read)
		begin
			state_next.shown.compare_sec = state_next.target.seconds;
			state_next.shown.compare_ns = state_next.target.nanoseconds;
			state_next.sec_written = 1'b0;
			state_next.ns_written = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign view_o = state_reg.shown;
	assign match_o = state_reg.match;

endmodule
`default_nettype wire

// file: design/ptp_rate_select.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptp_adjust_map.svh"

module ptp_rate_select
(
	input  wire logic           ref_clk_i,     // Reference clock.
	input  wire logic           rstn_i,        // Asynchronous reset, active low.
	input  wire logic           start_i,       // Pulse: begin temporary rate.
	input  wire logic [31:0]    duration_i,    // Temporary rate length in cycles.
	input  wire logic [31:0]    base_adj_i,    // Base rate adjustment word.
	input  wire logic [31:0]    temp_adj_i,    // Temporary rate adjustment word.
	output logic [`NS_W-1:0]    increment_o,   // Nanoseconds to add next cycle.
	output logic [31:0]         remaining_o    // Temporary cycles left.
);
	import ptp_adjust_pkg::*;

	typedef struct packed
	{
		logic [31:0]      subns;
		logic [31:0]      remaining;
		logic [`NS_W-1:0] increment;
	} rate_state_type;

	rate_state_type state_reg;
	rate_state_type state_next;

	always_comb
	begin
		logic [31:0] adj;
		logic [32:0] sum;
		adj = base_adj_i;
		sum = 33'h000000000;
		state_next = state_reg;
		if (state_reg.remaining != 32'h00000000)
		begin
			adj = temp_adj_i;
			state_next.remaining = state_reg.remaining - 32'h00000001;
		end
		if (start_i)
			state_next.remaining = duration_i;
		sum = {1'b0, state_reg.subns} + {3'h0, adj[`NS_W-1:0]};
		state_next.subns = sum[31:0];
		state_next.increment = `REF_PERIOD_NS;
		if (sum[32])
			state_next.increment = adj[`RATE_DIR_BIT] ? `PERIOD_FAST_NS : `PERIOD_SLOW_NS;
	end

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
			state_reg <= '{subns: 32'h00000000, remaining: 32'h00000000, increment: `REF_PERIOD_NS};
		else
			state_reg <= state_next;
	end

	assign increment_o = state_reg.increment;
	assign remaining_o = state_reg.remaining;

endmodule
`default_nettype wire

// file: verif/ptp_clock_adjust_checker.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptp_adjust_map.svh"

module ptp_clock_adjust_checker
(
	input  wire logic                          ref_clk_i,          // Reference clock.
	input  wire logic                          rstn_i,             // Asynchronous reset, active low.
	input  wire ptp_adjust_pkg::reg_req_type   reg_req_i,          // Register request.
	input  wire logic [31:0]                   reg_rdata_o,        // Read data.
	input  wire logic [31:0]                   base_rate_adj_i,    // Base rate word.
	input  wire logic [31:0]                   temp_rate_adj_i,    // Temporary rate word.
	input  wire ptp_adjust_pkg::ptp_time_type  clock_time_o,       // Running clock.
	input  wire logic                          event_a_o,          // Channel A event.
	input  wire logic                          event_b_o           // Channel B event.
);
	import ptp_adjust_pkg::*;

	logic [31:0]   step_reg;
	logic [3:0]    cfg_reg;
	logic [2:0]    quiet_reg;
	ptp_time_type  prev_reg;
	logic          cmd_wr;
	logic          quiet_now;
	logic [30:0]   ns_sum;
	logic [31:0]   sec_delta;

	assign cmd_wr = reg_req_i.wr && (reg_req_i.addr == `OFS_COMMAND);
	// Commands and any sub-nanosecond carry source make the plain 10 ns step unpredictable.
	assign quiet_now = (base_rate_adj_i[29:0] == 30'h0) && (temp_rate_adj_i[29:0] == 30'h0) && !cmd_wr;
	assign ns_sum = {1'b0, prev_reg.nanoseconds} + {1'b0, step_reg[29:0]};
	assign sec_delta = step_reg[31] ? {28'h0, step_reg[3:0]} : -{28'h0, step_reg[3:0]};

	always_ff @(posedge ref_clk_i or negedge rstn_i)
	begin
		if (!rstn_i)
		begin
			step_reg <= `RESET_WORD;
			cfg_reg <= 4'h0;
			quiet_reg <= 3'h0;
			prev_reg <= '0;
		end
		else
		begin
			prev_reg <= clock_time_o;
			quiet_reg <= {quiet_reg[1:0], quiet_now};
			if (reg_req_i.wr && (reg_req_i.addr == `OFS_STEP_ADJUST))
				step_reg <= reg_req_i.wdata;
			if (reg_req_i.wr && (reg_req_i.addr == `OFS_CHANNEL_CONFIG))
				cfg_reg <= reg_req_i.wdata[3:0];
		end
	end

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rstn_i);

	a_rdata_idle_zero: assert property (!$past(reg_req_i.rd) |-> reg_rdata_o == 32'h0)
		else $error("read data not zero outside the answer cycle");
	a_target_ns_reserved: assert property ($past(reg_req_i.rd) &&
		($past(reg_req_i.addr) == `OFS_COMPARE_NS_A || $past(reg_req_i.addr) == `OFS_COMPARE_NS_B)
		|-> reg_rdata_o[31:30] == 2'h0) else $error("target nanoseconds reserved bits set");
	a_rearm_ns_reserved: assert property ($past(reg_req_i.rd) &&
		($past(reg_req_i.addr) == `OFS_REARM_NS_A || $past(reg_req_i.addr) == `OFS_REARM_NS_B)
		|-> reg_rdata_o[31:30] == 2'h0) else $error("rearm nanoseconds reserved bits set");
	a_clock_tick_ten: assert property (&quiet_reg |-> clock_time_o.nanoseconds == prev_reg.nanoseconds + 30'hA)
		else $error("clock did not advance by 10 ns");
	a_step_seconds: assert property ($past(cmd_wr && reg_req_i.wdata[`CMD_STEP_SECONDS]) |->
		clock_time_o.seconds == prev_reg.seconds + sec_delta) else $error("seconds step wrong");
	a_step_nanos: assert property ($past(cmd_wr && reg_req_i.wdata[`CMD_STEP_NANOSECONDS]) |->
		((ns_sum < {1'b0, `NS_PER_SEC}) ? clock_time_o.nanoseconds == ns_sum[29:0] :
		(clock_time_o.nanoseconds == ns_sum[29:0] - `NS_PER_SEC && clock_time_o.seconds == prev_reg.seconds + 32'h1)))
		else $error("nanoseconds step wrong");
	a_event_a_enabled: assert property (event_a_o |-> cfg_reg[0] || $past(cfg_reg[0]))
		else $error("channel A event while disabled");
	a_event_b_enabled: assert property (event_b_o |-> cfg_reg[2] || $past(cfg_reg[2]))
		else $error("channel B event while disabled");
endmodule

bind ptp_clock_adjust ptp_clock_adjust_checker u_checker
(
	.ref_clk_i       (ref_clk_i),
	.rstn_i          (rstn_i),
	.reg_req_i       (reg_req_i),
	.reg_rdata_o     (reg_rdata_o),
	.base_rate_adj_i (base_rate_adj_i),
	.temp_rate_adj_i (temp_rate_adj_i),
	.clock_time_o    (clock_time_o),
	.event_a_o       (event_a_o),
	.event_b_o       (event_b_o)
);
`default_nettype wire

// file: verif/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "ptp_adjust_map.svh"

module tb_top;
	import ptp_adjust_pkg::*;

	logic          ref_clk_i;
	logic          rstn_i;
	reg_req_type   req;
	logic [31:0]   rdata;
	logic [31:0]   base_adj;
	logic [31:0]   temp_adj;
	ptp_time_type  now;
	logic          ev_a;
	logic          ev_b;
	logic [31:0]   rd_v;
	int            errors;
	int            checked;
	int            cyc;
	int            rd_cyc;
	int            na;
	int            nb;

	ptp_clock_adjust u_dut
	(
		.ref_clk_i       (ref_clk_i),
		.rstn_i          (rstn_i),
		.reg_req_i       (req),
		.reg_rdata_o     (rdata),
		.base_rate_adj_i (base_adj),
		.temp_rate_adj_i (temp_adj),
		.clock_time_o    (now),
		.event_a_o       (ev_a),
		.event_b_o       (ev_b)
	);

	always #2 ref_clk_i = ~ref_clk_i;

	always @(posedge ref_clk_i)
	begin
		cyc <= cyc + 1;
		if (ev_a === 1'b1)
			na <= na + 1;
		if (ev_b === 1'b1)
			nb <= nb + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			errors++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [8:0] a, input logic [31:0] d);
		@(posedge ref_clk_i);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge ref_clk_i);
		req.wr <= 1'b0;
	endtask

	task automatic rd(input logic [8:0] a);
		@(posedge ref_clk_i);
		req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		rd_cyc = cyc;
		@(posedge ref_clk_i);
		req.rd <= 1'b0;
		#1 rd_v = rdata;
	endtask

	task automatic rc(input logic [8:0] a, input logic [31:0] e);
		rd(a);
		chk(rd_v, e);
	endtask

	task automatic wait_ev(input logic chan_b);
		for (int i = 0; i < 200; i++)
		begin
			@(posedge ref_clk_i);
			#1;
			if ((chan_b ? ev_b : ev_a) === 1'b1)
				break;
		end
	endtask

	task automatic t_regs;
		for (int a = 'h124; a <= 'h148; a += 4)
			rc(a[8:0], 32'h0);
		wr(`OFS_TEMP_RATE_COUNT, 32'hFFFFFFFF);
		rc(`OFS_TEMP_RATE_COUNT, 32'hFFFFFFFF);
		wr(`OFS_STEP_ADJUST, 32'hFFFFFFFF);
		rc(`OFS_STEP_ADJUST, 32'hBFFFFFFF);
		wr(9'h100, 32'hFFFFFFFF);
		rc(9'h100, 32'h0);
		wr(`OFS_COMPARE_NS_A, 32'hFFFFFFFF);
		rc(`OFS_COMPARE_NS_A, 32'h3FFFFFFF);
		wr(`OFS_COMMAND, 32'h1);
		rc(`OFS_COMPARE_NS_A, 32'h0);
		rc(`OFS_COMPARE_SEC_A, 32'h0);
		wr(`OFS_TEMP_RATE_COUNT, 32'h0);
		wr(`OFS_CHANNEL_CONFIG, 32'hA);
		rc(`OFS_CHANNEL_CONFIG, 32'hA);
		wr(`OFS_CHANNEL_CONFIG, 32'h0);
	endtask

	task automatic t_step(input logic [31:0] s, input logic [31:0] c, input logic [31:0] dsec);
		logic [31:0] s0;
		wr(`OFS_STEP_ADJUST, s);
		rd(`OFS_CLOCK_SEC);
		s0 = rd_v;
		wr(`OFS_COMMAND, c);
		rc(`OFS_CLOCK_SEC, s0 + dsec);
	endtask

	// Returns the nanoseconds gained beyond 10 per cycle over a fixed window.
	task automatic t_rate(input logic start, output int extra);
		logic [31:0] n0;
		int c0;
		rd(`OFS_CLOCK_NS);
		n0 = rd_v;
		c0 = rd_cyc;
		if (start)
			wr(`OFS_COMMAND, 32'h10);
		repeat (30) @(posedge ref_clk_i);
		rd(`OFS_CLOCK_NS);
		extra = int'(rd_v - n0) - 10 * (rd_cyc - c0);
	endtask

	task automatic t_rates;
		int x;
		wr(`OFS_TEMP_RATE_COUNT, 32'd20);
		temp_adj <= 32'hBFFFFFFF;
		t_rate(1'b1, x);
		chk(32'(x >= 4 && x <= 5), 32'h1);
		rc(`OFS_TEMP_REMAINING, 32'h0);
		t_rate(1'b0, x);
		chk(32'(x), 32'h0);
		@(posedge ref_clk_i);
		temp_adj <= 32'h0;
		base_adj <= 32'h3FFFFFFF;
		t_rate(1'b0, x);
		chk(32'(x < 0), 32'h1);
		@(posedge ref_clk_i);
		base_adj <= 32'h0;
	endtask

	task automatic t_chan(input logic chan_b);
		logic [31:0] s;
		logic [31:0] t;
		logic [8:0] o;
		int a0;
		o = chan_b ? 9'h10 : 9'h0;
		a0 = na;
		rd(`OFS_CLOCK_SEC);
		s = rd_v;
		rd(`OFS_CLOCK_NS);
		t = rd_v + 32'd400;
		wr(`OFS_COMPARE_SEC_A + o, s);
		wr(`OFS_COMPARE_NS_A + o, t);
		wr(`OFS_REARM_NS_A + o, chan_b ? 32'hDDCD6500 : 32'd100);
		rc(`OFS_REARM_NS_A + o, chan_b ? 32'h1DCD6500 : 32'd100);
		wr(`OFS_REARM_SEC_A + o, chan_b ? s : 32'h0);
		wr(`OFS_CHANNEL_CONFIG, chan_b ? 32'h4 : 32'h3);
		wait_ev(chan_b);
		chk(32'(now.nanoseconds - t[29:0] >= 10 && now.nanoseconds - t[29:0] <= 20), 32'h1);
		repeat (35) @(posedge ref_clk_i);
		// Mode bits go back to zero before the next channel's registers are written.
		wr(`OFS_CHANNEL_CONFIG, 32'h0);
		repeat (3) @(posedge ref_clk_i);
		// The snapshot is taken only after both target halves were written.
		wr(`OFS_COMMAND, chan_b ? 32'h2 : 32'h1);
		rc(`OFS_COMPARE_SEC_A + o, s);
		if (chan_b)
		begin
			chk(32'(nb), 32'h1);
			chk(32'(na), 32'(a0));
			rc(`OFS_COMPARE_NS_B, 32'h1DCD6500);
		end
		else
		begin
			chk(32'(na >= 3), 32'h1);
			chk(32'(nb), 32'h0);
			rc(`OFS_COMPARE_NS_A, t + 32'(na) * 32'd100);
		end
	endtask

	task automatic print_verdict;
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		ref_clk_i = 1'b0;
		rstn_i = 1'b0;
		req = '0;
		base_adj = 32'h0;
		temp_adj = 32'h0;
		errors = 0;
		checked = 0;
		cyc = 0;
		na = 0;
		nb = 0;
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'b1;
		t_regs();
		t_step(32'h80000013, 32'h4, 32'h3);
		t_step(32'h00000012, 32'h4, 32'hFFFFFFFE);
		t_step(32'h3B9AC9FB, 32'h8, 32'h1);
		t_rates();
		t_chan(1'b0);
		t_chan(1'b1);
		print_verdict();
	end

	// The scenarios need well under 1000 cycles; this bound only cuts a hang short.
	initial
	begin
		#40000;
		errors++;
		print_verdict();
	end
endmodule
`default_nettype wire
